// file: src/audio_rx_pkg.sv
package audio_rx_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] left0_offset = 8'h08;
  localparam logic [7:0] right0_offset = 8'h0C;
  localparam logic [7:0] left1_offset = 8'h10;
  localparam logic [7:0] right1_offset = 8'h14;

  // ==========================================================
  // Control register fields
  localparam int ctrl_width = 10;
  localparam logic [9:0] ctrl_reset = 10'h000;
  localparam int ctrl_fmt_lsb = 0;
  localparam int ctrl_wlen_lsb = 2;
  localparam int ctrl_auto_off_bit = 4;
  localparam int ctrl_rate_lsb = 5;
  localparam int ctrl_am_en_bit = 7;
  localparam int ctrl_am_sel_lsb = 8;

  // ==========================================================
  // Status register fields
  localparam int stat_ratio_ok_bit = 0;
  localparam int stat_clk_err_bit = 1;
  localparam int stat_osc_bit = 2;
  localparam int stat_det_lsb = 3;
  localparam int stat_rate_lsb = 5;
  localparam int stat_pwm_lsb = 7;

  // ==========================================================
  // Serial formats and word length codes
  localparam logic [1:0] fmt_i2s = 2'h0;
  localparam logic [1:0] fmt_left = 2'h1;
  localparam logic [1:0] fmt_right = 2'h2;
  localparam int sample_width = 24;

  // Word length code to bit count: 16, 18, 20, 24
  function automatic logic [6:0] word_bits(input logic [1:0] code);
    case (code)
      2'h0: word_bits = 7'h10;
      2'h1: word_bits = 7'h12;
      2'h2: word_bits = 7'h14;
      default: word_bits = 7'h18;
    endcase
  endfunction : word_bits

  // ==========================================================
  // Rate classes, clock ratios, PWM ratios
  localparam logic [1:0] rate_32k = 2'h0;
  localparam logic [1:0] rate_normal = 2'h1;
  localparam logic [1:0] rate_double = 2'h2;
  localparam logic [1:0] rate_quad = 2'h3;
  localparam logic [6:0] sclk_ratio_32 = 7'h20;
  localparam logic [6:0] sclk_ratio_48 = 7'h30;
  localparam logic [6:0] sclk_ratio_64 = 7'h40;
  localparam logic [3:0] pwm_ratio_8 = 4'h8;
  localparam logic [3:0] pwm_ratio_7 = 4'h7;
  localparam logic [3:0] pwm_ratio_6 = 4'h6;

  // ==========================================================
  // Timing, in ns, and derived cycle counts
  localparam int clk_period_ns = 20;
  localparam int frame_timeout_ns = 40000;
  localparam int mclk_timeout_ns = 200;
  localparam int class_32k_ns = 27000;
  localparam int class_normal_ns = 15000;
  localparam int class_double_ns = 7500;
  localparam int frame_min_ns = 4000;
  localparam int frame_timeout_cyc = frame_timeout_ns / clk_period_ns;
  localparam int mclk_timeout_cyc = mclk_timeout_ns / clk_period_ns;
  localparam int class_32k_cyc = (class_32k_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int class_normal_cyc = (class_normal_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int class_double_cyc = (class_double_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int frame_min_cyc = (frame_min_ns + clk_period_ns - 1) / clk_period_ns;

endpackage : audio_rx_pkg

// file: src/slot_deserializer.sv
`timescale 1ns/1ps

module slot_deserializer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Serial line
  input wire logic sclk_rise,
  input wire logic lrclk,
  input wire logic sdin,
  // Format setup
  input wire logic [1:0] fmt,
  input wire logic [1:0] wlen,
  // Captured words
  output logic [23:0] left_word,
  output logic [23:0] right_word,
  output logic right_done
);

  // ==========================================================
  // Slot framing and word extraction
  logic lr_prev;
  logic [31:0] shreg;
  logic [6:0] bit_cnt;

  wire slot_end = sclk_rise && (lrclk != lr_prev);
  wire [6:0] wbits = audio_rx_pkg::word_bits(wlen);
  wire is_rj = (fmt == audio_rx_pkg::fmt_right);
  wire [6:0] lead = (fmt == audio_rx_pkg::fmt_i2s) ? 7'h01 : 7'h00;
  wire [6:0] need = wbits + lead;
  wire [7:0] span = {1'b0, bit_cnt} + 8'h01; // Slot bits plus the one arriving now
  wire [7:0] drop = is_rj ? 8'h01 :
    (span > {1'b0, need} ? span - {1'b0, need} : 8'h00);
  // An I2S word that fills its slot ends on the first bit of the next slot
  wire [32:0] slot_bits = {shreg, sdin};
  wire [32:0] moved = slot_bits >> drop;
  wire [31:0] mask = ~(32'hFFFF_FFFF << wbits);
  wire [31:0] kept = moved[31:0] & mask;
  wire [31:0] msb_up = kept << (7'h18 - wbits);
  wire [23:0] word = msb_up[23:0];
  wire slot_left = (fmt == audio_rx_pkg::fmt_i2s) ? !lr_prev : lr_prev;

  // Shift in on every bit-clock rise, MSB first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lr_prev <= 1'b0;
      shreg <= 32'h0000_0000;
      bit_cnt <= 7'h00;
    end else if (sclk_rise) begin
      shreg <= {shreg[30:0], sdin};
      lr_prev <= lrclk;
      bit_cnt <= slot_end ? 7'h01 : (bit_cnt == 7'h7F ? bit_cnt : bit_cnt + 7'h01);
    end
  end

  // Hand the finished slot to its channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_word <= 24'h00_0000;
      right_word <= 24'h00_0000;
      right_done <= 1'b0;
    end else begin
      right_done <= slot_end && !slot_left;
      if (slot_end && slot_left) left_word <= word;
      if (slot_end && !slot_left) right_word <= word;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_i2s_left_slot: assert property (
    fmt == audio_rx_pkg::fmt_i2s && slot_end && !lr_prev |=> left_word == $past(word) && !right_done)
    else $error("I2S low phase word not routed to left");

endmodule : slot_deserializer

// file: src/audio_serial_input_clock_detect.sv
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps

// What this block does
// - Check bit clock is exactly 32, 48 or 64 times the sample rate.
// - Frame clock runs at the sample rate; one frame per frame-clock cycle.
// - Use master clock; switch to internal oscillator when master clock stalls.
// - Auto-classify rate as 32k, normal, double or quad speed.
// - Software may disable auto-detect and set the rate class itself.
// - AM avoidance mode sets PWM output to 7, 8 or 6 times fs.
// - Two serial data inputs feed all output channels.
// - Word lengths 16, 18, 20, 24 bits in all three formats.
// - I2S: frame clock low is left, high is right.
// - I2S: first data bit one bit clock after frame clock change.
// - MSB first; data sampled on bit clock rising edge.
// - I2S and left justified: trailing bits after the word ignored.
// - Left and right justified: frame clock high is left, low is right.
// - Left justified: MSB coincides with frame clock transition.
// - Right justified: LSB sits in the last bit clock before transition.
// - Right justified: leading bits before the word ignored.
// - Samples are two's-complement signed values.
// - Between frame clock rises there are 32 to 64 bit clock rises.

module audio_serial_input_clock_detect (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Serial audio pins
  input wire logic mclk,
  input wire logic sclk,
  input wire logic lrclk,
  input wire logic [1:0] serial_data_inputs,
  // Clock control
  output logic osc_select,
  output logic [1:0] rate_class,
  output logic [3:0] pwm_ratio,
  output logic clock_error,
  // Samples, 24-bit signed
  output logic [23:0] sample_left0,
  output logic [23:0] sample_right0,
  output logic [23:0] sample_left1,
  output logic [23:0] sample_right1,
  output logic sample_strobe
);

  // ==========================================================
  // Register bus
  logic [9:0] ctrl_reg;
  logic wr_pend;
  logic [7:0] wr_addr;

  // Address phase decode
  wire bus_take = hsel && htrans[1] && hready;
  wire in_map = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
  wire word_size = (hsize == 3'h2);
  wire ctrl_write = wr_pend && (wr_addr == audio_rx_pkg::ctrl_offset);

  // Write data phase follows the captured address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= bus_take && hwrite && in_map && word_size;
      wr_addr <= haddr[7:0];
    end
  end

  // Control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= audio_rx_pkg::ctrl_reset;
    end else if (ctrl_write) begin
      ctrl_reg <= hwdata[9:0];
    end
  end

  // Control fields
  wire [1:0] fmt = ctrl_reg[audio_rx_pkg::ctrl_fmt_lsb +: 2];
  wire [1:0] wlen = ctrl_reg[audio_rx_pkg::ctrl_wlen_lsb +: 2];
  wire auto_off = ctrl_reg[audio_rx_pkg::ctrl_auto_off_bit];
  wire [1:0] manual_class = ctrl_reg[audio_rx_pkg::ctrl_rate_lsb +: 2];
  wire am_on = ctrl_reg[audio_rx_pkg::ctrl_am_en_bit];
  wire [1:0] am_sel = ctrl_reg[audio_rx_pkg::ctrl_am_sel_lsb +: 2];

  // ==========================================================
  // Pin edges
  logic sclk_prev;
  logic lrclk_prev;
  logic mclk_prev;

  wire sclk_rise = sclk && !sclk_prev;
  wire frame_rise = lrclk && !lrclk_prev;
  wire mclk_edge = mclk ^ mclk_prev;

  // Previous pin levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_prev <= 1'b1; // A pin already high at release is no rise
      lrclk_prev <= 1'b1;
      mclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk;
      lrclk_prev <= lrclk;
      mclk_prev <= mclk;
    end
  end

  // ==========================================================
  // Master clock watch and source select
  localparam logic [3:0] mclk_limit = 4'(audio_rx_pkg::mclk_timeout_cyc);
  logic [3:0] mclk_idle;

  wire [3:0] next_mclk_idle = mclk_edge ? 4'h0 :
    (mclk_idle >= mclk_limit ? mclk_idle : mclk_idle + 4'h1);
  wire next_osc_select = (next_mclk_idle >= mclk_limit);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mclk_idle <= 4'h0;
      osc_select <= 1'b1;
    end else begin
      mclk_idle <= next_mclk_idle;
      osc_select <= next_osc_select;
    end
  end

  // ==========================================================
  // Frame measurement: bit clocks and system cycles per frame
  localparam logic [11:0] frame_limit = 12'(audio_rx_pkg::frame_timeout_cyc);
  localparam logic [11:0] frame_min = 12'(audio_rx_pkg::frame_min_cyc);
  logic [6:0] sclk_count;
  logic [11:0] frame_cycles;
  logic ratio_ok;
  logic [1:0] detected_class;

  // Map a frame length in cycles to a rate class
  function automatic logic [1:0] class_of(input logic [11:0] c);
    if (c >= 12'(audio_rx_pkg::class_32k_cyc)) class_of = audio_rx_pkg::rate_32k;
    else if (c >= 12'(audio_rx_pkg::class_normal_cyc)) class_of = audio_rx_pkg::rate_normal;
    else if (c >= 12'(audio_rx_pkg::class_double_cyc)) class_of = audio_rx_pkg::rate_double;
    else class_of = audio_rx_pkg::rate_quad;
  endfunction : class_of

  wire ratio_hit = (sclk_count == audio_rx_pkg::sclk_ratio_32) ||
    (sclk_count == audio_rx_pkg::sclk_ratio_48) ||
    (sclk_count == audio_rx_pkg::sclk_ratio_64);
  wire frame_long = (frame_cycles >= frame_min);
  wire frame_lost = (frame_cycles >= frame_limit);
  wire [1:0] frame_class = class_of(frame_cycles);

  // Count bit-clock rises inside one frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_count <= 7'h00;
    end else if (frame_rise) begin
      sclk_count <= sclk_rise ? 7'h01 : 7'h00;
    end else if (sclk_rise && sclk_count != 7'h7F) begin
      sclk_count <= sclk_count + 7'h01;
    end
  end

  // Count system cycles per frame, saturating at the stall limit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_cycles <= frame_limit;
    end else if (frame_rise) begin
      frame_cycles <= 12'h001;
    end else if (!frame_lost) begin
      frame_cycles <= frame_cycles + 12'h001;
    end
  end

  // Judge each completed frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ratio_ok <= 1'b0;
      detected_class <= audio_rx_pkg::rate_normal;
    end else if (frame_rise) begin
      ratio_ok <= ratio_hit && frame_long && !frame_lost;
      if (frame_long && !frame_lost) detected_class <= frame_class;
    end
  end

  // ==========================================================
  // Clock control settings
  wire manual_mode = auto_off || am_on;
  wire [1:0] next_rate_class = manual_mode ? manual_class : detected_class;
  wire [3:0] am_ratio = (am_sel == 2'h1) ? audio_rx_pkg::pwm_ratio_7 :
    (am_sel == 2'h2) ? audio_rx_pkg::pwm_ratio_6 : audio_rx_pkg::pwm_ratio_8;
  wire [3:0] next_pwm_ratio = am_on ? am_ratio : audio_rx_pkg::pwm_ratio_8;
  wire next_clock_error = !ratio_ok || frame_lost;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_class <= audio_rx_pkg::rate_normal;
      pwm_ratio <= audio_rx_pkg::pwm_ratio_8;
      clock_error <= 1'b1;
    end else begin
      rate_class <= next_rate_class;
      pwm_ratio <= next_pwm_ratio;
      clock_error <= next_clock_error;
    end
  end

  // ==========================================================
  // Two data lanes share frame timing
  logic [23:0] lane_left [2];
  logic [23:0] lane_right [2];
  logic [1:0] lane_done;

  for (genvar i = 0; i < 2; i++) begin : g_lane
    slot_deserializer u_slot (
      .hclk(hclk),
      .hresetn(hresetn),
      .sclk_rise(sclk_rise),
      .lrclk(lrclk),
      .sdin(serial_data_inputs[i]),
      .fmt(fmt),
      .wlen(wlen),
      .left_word(lane_left[i]),
      .right_word(lane_right[i]),
      .right_done(lane_done[i])
    );
  end

  // Publish a frame when its second slot ends; zero while clocks are bad
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_left0 <= 24'h00_0000;
      sample_right0 <= 24'h00_0000;
      sample_left1 <= 24'h00_0000;
      sample_right1 <= 24'h00_0000;
      sample_strobe <= 1'b0;
    end else if (next_clock_error) begin
      sample_left0 <= 24'h00_0000;
      sample_right0 <= 24'h00_0000;
      sample_left1 <= 24'h00_0000;
      sample_right1 <= 24'h00_0000;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= lane_done[0];
      if (lane_done[0]) begin
        sample_left0 <= lane_left[0];
        sample_right0 <= lane_right[0];
        sample_left1 <= lane_left[1];
        sample_right1 <= lane_right[1];
      end
    end
  end

  // ==========================================================
  // Read path: data stands in the cycle after the address phase
  wire [31:0] status_word = {21'h00_0000, pwm_ratio, rate_class, detected_class,
    osc_select, clock_error, ratio_ok};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_word =
    !in_map ? 32'h0000_0000 :
    (ra == audio_rx_pkg::ctrl_offset) ? {22'h00_0000, ctrl_reg} :
    (ra == audio_rx_pkg::status_offset) ? status_word :
    (ra == audio_rx_pkg::left0_offset) ? {{8{sample_left0[23]}}, sample_left0} :
    (ra == audio_rx_pkg::right0_offset) ? {{8{sample_right0[23]}}, sample_right0} :
    (ra == audio_rx_pkg::left1_offset) ? {{8{sample_left1[23]}}, sample_left1} :
    (ra == audio_rx_pkg::right1_offset) ? {{8{sample_right1[23]}}, sample_right1} :
    32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (bus_take && !hwrite) ? rd_word : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_ratio_accept: assert property (
    frame_rise && ratio_hit && frame_long && !frame_lost |=> ratio_ok)
    else $error("Valid bit clock ratio not accepted");
  a_ratio_reject: assert property (
    frame_rise && !ratio_hit |=> !ratio_ok ##1 clock_error)
    else $error("Bad bit clock ratio did not raise clock error");
  a_osc_fallback: assert property (
    mclk_idle >= mclk_limit && !mclk_edge |=> osc_select)
    else $error("Oscillator not selected with master clock stalled");
  a_mclk_return: assert property (
    mclk_edge |=> !osc_select)
    else $error("Master clock edge did not reselect master clock");
  a_auto_class: assert property (
    frame_rise && frame_long && !frame_lost && !manual_mode ##1 !manual_mode
    |=> rate_class == $past(frame_class, 2))
    else $error("Detected rate class not applied");
  a_manual_class: assert property (
    manual_mode |=> rate_class == $past(manual_class))
    else $error("Manual rate class not applied");
  a_am_ratio: assert property (
    am_on && am_sel == 2'h2 |=> pwm_ratio == audio_rx_pkg::pwm_ratio_6)
    else $error("AM mode ratio six not applied");
  a_normal_ratio: assert property (
    !am_on |=> pwm_ratio == audio_rx_pkg::pwm_ratio_8)
    else $error("PWM ratio not eight outside AM mode");
  a_err_zero: assert property (
    clock_error |-> sample_left0 == 24'h00_0000 && sample_right1 == 24'h00_0000 && !sample_strobe)
    else $error("Samples not held at zero during clock error");
  a_read_ctrl: assert property (
    bus_take && !hwrite && haddr == 32'h0000_0000 |=> hrdata == {22'h00_0000, $past(ctrl_reg)})
    else $error("Control register read back wrong");

  cp_frame_ok: cover property (frame_rise && ratio_hit && frame_long);
  cp_osc: cover property (osc_select ##1 !osc_select);
  cp_strobe: cover property (sample_strobe);
  cp_manual: cover property (manual_mode && frame_rise);

endmodule : audio_serial_input_clock_detect

// file: verif/audio_source_model.sv
`timescale 1ns/1ps

// ==========================================================
// Serial audio source: frame, bit clock and two data lanes
module audio_source_model (
  // Clock
  input wire logic hclk,
  // Frame setup from the bench
  input wire logic run,
  input wire logic [4:0] half,
  input wire logic [5:0] slot,
  input wire logic [1:0] fmt,
  input wire logic [4:0] wbits,
  input wire logic [95:0] words,
  // Serial pins
  output logic sclk,
  output logic lrclk,
  output logic [1:0] sdata
);
  logic [95:0] held;
  logic [95:0] last;
  logic [1:0] hf;
  int hs;
  int hh;
  int hw;
  int j;

  initial begin
    sclk = 1'b1;
    lrclk = 1'b0;
    sdata = 2'h0;
    last = '0;
  end

  // One frame per frame clock cycle, left slot then right slot; setup latched per frame
  always begin
    @(posedge hclk);
    if (run) begin
      held = words;
      hf = fmt;
      hs = slot;
      hh = half;
      hw = wbits;
      for (int ch = 0; ch < 2; ch++) begin
        for (int k = 0; k < hs; k++) begin
          repeat (hh) @(posedge hclk);
          sclk <= 1'b0;
          if (k == 0) begin
            lrclk <= (hf == audio_rx_pkg::fmt_i2s) ? ch[0] : ~ch[0];
          end
          j = (hf == audio_rx_pkg::fmt_i2s) ? k - 1 : k;
          if (hf == audio_rx_pkg::fmt_right) begin
            j = k - (hs - hw);
          end
          for (int l = 0; l < 2; l++) begin
            if (j >= 0 && j < hw) begin
              sdata[l] <= held[95 - 48 * l - 24 * ch - j];
            end else if (hf == audio_rx_pkg::fmt_i2s && k == 0) begin
              // The previous word's LSB spills over when the word fills its slot
              sdata[l] <= ch[0] ? held[96 - 48 * l - hw] : last[72 - 48 * l - hw];
            end else begin
              sdata[l] <= ~sdata[l]; // Filler bits keep changing
            end
          end
          repeat (hh) @(posedge hclk);
          sclk <= 1'b1;
        end
      end
      last = held;
    end else begin
      sdata <= ~sdata; // Idle lines wander, clocks stand still
    end
  end
endmodule : audio_source_model

// file: verif/audio_serial_input_clock_detect_tb_top.sv
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin $display("mismatch %s expected %h seen %h", nm, ex, got); err_total++; end end

module audio_serial_input_clock_detect_tb_top;
  // ==========================================================
  // Signals
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic mclk = 1'b0;
  logic mclk_on = 1'b1;
  logic run = 1'b0;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout, hresp, sclk, lrclk, osc_select, clock_error, sample_strobe;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] sdata, rate_class, fmt;
  logic [3:0] pwm_ratio;
  logic [23:0] sample_left0, sample_right0, sample_left1, sample_right1;
  logic [4:0] half, wbits;
  logic [5:0] slot;
  logic [95:0] words;
  int err_total = 0;
  int check_count = 0;
  int seed;
  int cnt;
  typedef struct {logic [95:0] w; logic [1:0] r;} note_t;
  note_t note_q[$];
  note_t nt;
  note_t nt2;
  int wb_t[4] = '{16, 18, 20, 24};
  logic [5:0] slot_t[4] = '{6'd16, 6'd24, 6'd24, 6'd32};
  logic [4:0] half_t[4] = '{5'd4, 5'd8, 5'd4, 5'd11};
  logic [1:0] rate_t[4] = '{audio_rx_pkg::rate_quad, audio_rx_pkg::rate_normal,
                           audio_rx_pkg::rate_double, audio_rx_pkg::rate_32k};
  logic [3:0] pwm_t[4] = '{audio_rx_pkg::pwm_ratio_8, audio_rx_pkg::pwm_ratio_7,
                          audio_rx_pkg::pwm_ratio_6, audio_rx_pkg::pwm_ratio_8};

  // Clocks: bus clock and a master clock that can be stopped
  always #10 hclk = ~hclk;
  always @(posedge hclk) if (mclk_on) mclk <= ~mclk;

  audio_serial_input_clock_detect DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mclk(mclk), .sclk(sclk),
    .lrclk(lrclk), .serial_data_inputs(sdata), .osc_select(osc_select),
    .rate_class(rate_class), .pwm_ratio(pwm_ratio), .clock_error(clock_error),
    .sample_left0(sample_left0), .sample_right0(sample_right0),
    .sample_left1(sample_left1), .sample_right1(sample_right1),
    .sample_strobe(sample_strobe)
  );

  audio_source_model src (
    .hclk(hclk), .run(run), .half(half), .slot(slot), .fmt(fmt), .wbits(wbits),
    .words(words), .sclk(sclk), .lrclk(lrclk), .sdata(sdata)
  );

  // ==========================================================
  // Result watcher: each strobe with a note waiting is matched to the oldest note
  always @(negedge hclk) begin
    if (sample_strobe === 1'b1 && note_q.size() > 0) begin
      nt = note_q.pop_front();
      `CHK("left0", nt.w[95:72], sample_left0)
      `CHK("right0", nt.w[71:48], sample_right0)
      `CHK("left1", nt.w[47:24], sample_left1)
      `CHK("right1", nt.w[23:0], sample_right1)
      `CHK("rate", nt.r, rate_class)
    end
  end

  // ==========================================================
  // Bus and wait tasks
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    rd = hrdata;
    if (n >= 100) begin
      err_total++;
      stop_test();
    end
  endtask : wait_rdy

  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    hsel <= 1'b0;
  endtask : ahb_xfer

  task automatic wait_strobes(input int n);
    int c;
    c = 0;
    while (n > 0 && c < 20000) begin
      @(negedge hclk);
      c++;
      if (sample_strobe === 1'b1) n--;
    end
    if (n > 0) begin
      err_total++;
      stop_test();
    end
  endtask : wait_strobes

  task automatic wait_err(input logic v);
    int c;
    c = 0;
    while (clock_error !== v && c < 6000) begin
      @(negedge hclk);
      c++;
    end
    if (c >= 6000) begin
      err_total++;
      stop_test();
    end
  endtask : wait_err

  // One format and word length, with its own slot size and bit clock rate
  task automatic run_combo(input logic [1:0] f, input logic [1:0] w);
    logic [23:0] m;
    m = 24'hff_ffff << (24 - wb_t[w]);
    ahb_xfer(1'b1, audio_rx_pkg::ctrl_offset, {28'h000_0000, w, f});
    fmt <= f;
    wbits <= 5'(wb_t[w]);
    slot <= slot_t[w];
    half <= half_t[w];
    words <= {$random(seed), $random(seed), $random(seed)};
    wait_strobes(3);
    @(posedge hclk); // Notes go in after the watcher has passed the third strobe
    nt2.w = words & {m, m, m, m};
    nt2.r = rate_t[w];
    note_q.push_back(nt2);
    note_q.push_back(nt2);
    wait_strobes(2);
  endtask : run_combo

  // ==========================================================
  // Main sequence
  initial begin
    seed = 50535;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    half = 5'd4;
    slot = 6'd32;
    fmt = 2'h0;
    wbits = 5'd24;
    words = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `CHK("rate_rst", 2'h1, rate_class)
    `CHK("pwm_rst", 4'h8, pwm_ratio)
    `CHK("err_rst", 1'b1, clock_error)
    ahb_xfer(1'b0, audio_rx_pkg::ctrl_offset, 32'h0000_0000);
    `CHK("ctrl_rst", 32'h0000_0000, rd)
    run <= 1'b1;
    for (int i = 0; i < 12; i++) run_combo(2'(i % 3), 2'(i / 3));
    // Forty bit clocks per frame is refused and mutes the samples
    slot <= 6'd20;
    wait_err(1'b1);
    @(negedge hclk);
    `CHK("mute", 96'h0, {sample_left0, sample_right0, sample_left1, sample_right1})
    ahb_xfer(1'b0, audio_rx_pkg::status_offset, 32'h0000_0000);
    `CHK("ratio_ok", 1'b0, rd[0])
    cnt = 0;
    repeat (1500) @(negedge hclk) if (sample_strobe === 1'b1) cnt++;
    `CHK("no_strobe", 0, cnt)
    slot <= 6'd32;
    wait_err(1'b0);
    // Frame clock stops
    run <= 1'b0;
    wait_err(1'b1);
    `CHK("stall", 96'h0, {sample_left0, sample_right0, sample_left1, sample_right1})
    run <= 1'b1;
    wait_err(1'b0);
    // Master clock loss selects the oscillator
    mclk_on <= 1'b0;
    repeat (20) @(negedge hclk);
    `CHK("osc_on", 1'b1, osc_select)
    mclk_on <= 1'b1;
    repeat (20) @(negedge hclk);
    `CHK("osc_off", 1'b0, osc_select)
    // Manual rate class overrides detection
    ahb_xfer(1'b1, audio_rx_pkg::ctrl_offset, 32'h0000_007e);
    wait_strobes(2);
    `CHK("man_rate", audio_rx_pkg::rate_quad, rate_class)
    ahb_xfer(1'b0, audio_rx_pkg::status_offset, 32'h0000_0000);
    `CHK("det_rate", audio_rx_pkg::rate_32k, rd[4:3])
    `CHK("eff_rate", audio_rx_pkg::rate_quad, rd[6:5])
    ahb_xfer(1'b0, audio_rx_pkg::left0_offset, 32'h0000_0000);
    `CHK("signed", {{8{words[95]}}, words[95:72]}, rd)
    // AM mode with the rate set by software
    for (int k = 0; k < 4; k++) begin
      ahb_xfer(1'b1, audio_rx_pkg::ctrl_offset, 32'h0000_00fe | (k << 8));
      repeat (4) @(negedge hclk);
      `CHK("pwm", pwm_t[k], pwm_ratio)
    end
    // Unmapped place reads zero and ignores writes
    ahb_xfer(1'b1, 8'h40, 32'hffff_ffff);
    ahb_xfer(1'b0, 8'h40, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
    // A byte-size write must leave the control register alone
    hsize <= 3'h0;
    ahb_xfer(1'b1, audio_rx_pkg::ctrl_offset, 32'h0000_0000);
    hsize <= 3'h2;
    ahb_xfer(1'b0, audio_rx_pkg::ctrl_offset, 32'h0000_0000);
    `CHK("ctrl_kept", 32'h0000_03fe, rd)
    `CHK("hresp", 1'b0, hresp)
    stop_test();
  end
endmodule : audio_serial_input_clock_detect_tb_top
